// ### bench/tb_top.sv
// Purpose: self-checking bench for the serial video link transmitter
// Assumes: receiver model answers hot-plug and lock
// Notes:   word notes queued by driver, popped on each load
`timescale 1ns/1ps
module tb_top
    import vsltx_pkg::*;
;
    logic               clock, sys_rst, de_in, power_down_n, emphasis_sel, drive_level_sel;
    logic               width_sel, low_freq_sel, de_invert_n, latch_edge_sel;
    logic               bit_error_test_en, factory_test_a, factory_test_b, connect, drop_lock;
    logic               hot_plug_n, rx_lock_n, serial_lane_out, ser_word_load;
    logic               link_active, training_active;
    logic [SER_MAX-1:0] ser_word_out, word_a;
    logic [SER_MAX-1:0] exp_q[$];
    logic [63:0]        rnd;
    vsltx_pixel_s       pix;
    vsltx_link_cfg_s    link_cfg_out;
    int                 n_errors, checks, gap;
    assign de_in = de_invert_n ? pix.de : !pix.de;
    vsltx_core vsltx_core_i (.clock, .sys_rst, .red_channel_in(pix.red),
        .green_channel_in(pix.green), .blue_channel_in(pix.blue), .user_aux_bits(pix.aux),
        .hsync_in(pix.hsync), .vsync_in(pix.vsync), .de_in, .power_down_n, .emphasis_sel,
        .drive_level_sel, .width_sel, .low_freq_sel, .de_invert_n, .latch_edge_sel,
        .bit_error_test_en, .factory_test_a, .factory_test_b, .hot_plug_n, .rx_lock_n,
        .serial_lane_out, .ser_word_out, .ser_word_load, .link_cfg_out, .link_active,
        .training_active);
    vsltx_rx_model vsltx_rx_model_i (.clock, .sys_rst, .ser_word_out, .ser_word_load,
        .connect, .drop_lock, .hot_plug_n, .rx_lock_n);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input string what, input logic [SER_MAX-1:0] seen,
                         input logic [SER_MAX-1:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [SER_MAX-1:0] exp_word(input vsltx_pixel_s p);
        if (p.de) begin
            return 40'({p.aux, p.red, p.green, p.blue, 1'b1, 5'h0});
        end
        return {K28_5_RD_N, 24'h00_0000, 1'b0, p.hsync, p.vsync, 1'b0, 2'h0};
    endfunction
    task automatic wait_loads(input int n);
        int t;
        t = 0;
        while (n > 0 && t < 2000) begin
            @(negedge clock);
            t++;
            if (ser_word_load === 1'b1) begin
                n--;
            end
        end
        check("load", n, 0);
    endtask
    task automatic wait_st(input logic tr, input logic lk);
        int t;
        t = 0;
        while (!(training_active === tr && link_active === lk) && t < 400) begin
            @(negedge clock);
            t++;
        end
        check("state", {training_active, link_active}, {tr, lk});
    endtask
    task automatic send_pix();
        logic [SER_MAX-1:0] e;
        @(negedge clock);
        rnd = {$urandom, $urandom};
        pix <= rnd[$bits(vsltx_pixel_s)-1:0];
        de_invert_n <= rnd[40];
        latch_edge_sel <= rnd[41];
        emphasis_sel <= rnd[42];
        drive_level_sel <= rnd[43];
        wait_loads(2);
        exp_q.push_back(exp_word(pix));
        wait_loads(1);
        e = exp_word(pix);
        for (int k = 0; k < SER_32; k++) begin
            @(negedge clock);
            check("lane", serial_lane_out, e[SER_MAX-1-k]);
        end
        check("cfg", link_cfg_out, {1'b1, emphasis_sel, drive_level_sel, 2'h0});
    endtask
    task automatic quiet_check(input string what);
        repeat (6) @(negedge clock);
        repeat (40) begin
            @(negedge clock);
            check(what, {serial_lane_out, link_active}, 2'h2);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watches loaded words
    always @(posedge clock) begin
        if (ser_word_load === 1'b1 && exp_q.size() > 0) begin
            check("word", ser_word_out, exp_q.pop_front());
        end
    end
    initial begin
        #500_000;
        n_errors++;
        summarize();
    end
    initial begin
        rnd = $urandom(32'hc88d);
        {sys_rst, power_down_n, drive_level_sel, de_invert_n, latch_edge_sel} = 5'h1f;
        {emphasis_sel, width_sel, low_freq_sel, bit_error_test_en} = 4'h0;
        {factory_test_a, factory_test_b, connect, drop_lock} = 4'h0;
        pix = '0;
        repeat (12) @(negedge clock);
        check("rst", {serial_lane_out, link_active, training_active}, 3'h4);
        sys_rst = 1'b0;
        connect <= 1'b1;
        wait_st(1'b1, 1'b1);
        wait_st(1'b0, 1'b1);
        repeat (12) send_pix();
        drop_lock <= 1'b1;
        wait_st(1'b1, 1'b1);
        wait_loads(1);
        exp_q.push_back(TRAIN_WORD);
        wait_loads(1);
        drop_lock <= 1'b0;
        wait_st(1'b0, 1'b1);
        // narrow mode, restart by power-down pulse
        {width_sel, low_freq_sel, power_down_n} <= 3'h6;
        quiet_check("pdn");
        power_down_n <= 1'b1;
        wait_st(1'b0, 1'b1);
        check("cfg24", link_cfg_out, {1'b1, emphasis_sel, drive_level_sel, 2'h3});
        wait_loads(1);
        gap = 0;
        do begin
            @(negedge clock);
            gap++;
        end while (ser_word_load !== 1'b1 && gap < 100);
        check("gap", gap, SER_24);
        pix <= 37'h1f_ffff_ffff;
        wait_loads(2);
        word_a = ser_word_out;
        pix.aux <= 2'h0;
        wait_loads(2);
        check("aux", ser_word_out, word_a);
        bit_error_test_en <= 1'b1;
        wait_loads(3);
        word_a = ser_word_out;
        check("bet", ser_word_out[39:10], {3{ser_word_out[9:0]}});
        wait_loads(1);
        check("betchg", ser_word_out == word_a, 0);
        bit_error_test_en <= 1'b0;
        factory_test_a <= 1'b1;
        quiet_check("ftest");
        summarize();
    end
endmodule

// ### bench/vsltx_rx_model.sv
// Purpose: remote receiver model driving hot-plug and lock status
// Assumes: open-drain status lines with pull-ups
// Notes:   locks after LOCK_WORDS training words
`timescale 1ns/1ps
module vsltx_rx_model
    import vsltx_pkg::*;
#(
    parameter int LOCK_WORDS = 2
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               sys_rst,
    // lane words
    input  wire logic [SER_MAX-1:0] ser_word_out,
    input  wire logic               ser_word_load,
    // scenario control
    input  wire logic               connect,
    input  wire logic               drop_lock,
    // status lines
    output logic                    hot_plug_n,
    output logic                    rx_lock_n
);
    int seen_reg;
    int idle_reg;
    ////////////////////////////////////////////////////////////////////////////
    // lane silent too long: lock is lost
    always_ff @(posedge clock) begin
        if (sys_rst || ser_word_load) begin
            idle_reg <= 0;
        end else if (idle_reg < 64) begin
            idle_reg <= idle_reg + 1;
        end
    end
    // count training words
    always_ff @(posedge clock) begin
        if (sys_rst || !connect || drop_lock || idle_reg > 44) begin
            seen_reg <= 0;
        end else if (ser_word_load && ser_word_out == TRAIN_WORD && seen_reg < LOCK_WORDS) begin
            seen_reg <= seen_reg + 1;
        end
    end
    // released lines sit at pull-up level
    assign hot_plug_n = !connect;
    assign rx_lock_n  = !(connect && !drop_lock && seen_reg == LOCK_WORDS);
endmodule

// ### core/vsltx_core.sv
// Purpose: pixel capture, framing and serialization for one serial video lane
// Assumes: all straps static, sys_rst synchronous active high
// Notes:   analog stage only sees the config struct
`timescale 1ns/1ps
module vsltx_core
    import vsltx_pkg::*;
#(
    parameter int SER_WORD_W = SER_MAX
) (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            sys_rst,
    // pixel inputs
    input  wire logic [9:0]      red_channel_in,
    input  wire logic [9:0]      green_channel_in,
    input  wire logic [9:0]      blue_channel_in,
    input  wire logic [1:0]      user_aux_bits,
    input  wire logic            hsync_in,
    input  wire logic            vsync_in,
    input  wire logic            de_in,
    // straps
    input  wire logic            power_down_n,
    input  wire logic            emphasis_sel,
    input  wire logic            drive_level_sel,
    input  wire logic            width_sel,
    input  wire logic            low_freq_sel,
    input  wire logic            de_invert_n,
    input  wire logic            latch_edge_sel,
    input  wire logic            bit_error_test_en,
    input  wire logic            factory_test_a,
    input  wire logic            factory_test_b,
    // receiver status
    input  wire logic            hot_plug_n,
    input  wire logic            rx_lock_n,
    // serial side
    output logic                 serial_lane_out,
    output logic [SER_MAX-1:0]   ser_word_out,
    output logic                 ser_word_load,
    output vsltx_link_cfg_s      link_cfg_out,
    output logic                 link_active,
    output logic                 training_active
);
    ////////////////////////////////////////////////////////////////////////
    vsltx_pixel_s           pix_now;
    vsltx_pixel_s           pix_fall_reg;
    vsltx_pixel_s           pix_reg;
    vsltx_state_e           state_reg;
    vsltx_state_e           state_next;
    logic [SER_MAX-1:0]     shift_reg;
    logic [CNT_W-1:0]       bit_cnt_reg;
    logic [CNT_W-1:0]       word_len;
    logic [15:0]            prbs_reg;
    logic [15:0]            scr_reg;
    logic                   rd_reg;
    logic [SER_MAX-1:0]     word_next;
    logic [SYM_W-1:0]       bet_sym;
    logic                   word_end;
    logic                   run_ok;

    assign run_ok   = power_down_n && !factory_test_a && !factory_test_b;
    assign word_len = width_sel ? CNT_W'(SER_24) : CNT_W'(SER_32);
    assign word_end = (bit_cnt_reg == word_len - CNT_W'(1));

    ////////////////////////////////////////////////////////////////////////
    // pixel capture
    always_comb begin
        pix_now.red   = red_channel_in;
        pix_now.green = green_channel_in;
        pix_now.blue  = blue_channel_in;
        pix_now.aux   = width_sel ? 2'h0 : user_aux_bits;
        pix_now.hsync = hsync_in;
        pix_now.vsync = vsync_in;
        pix_now.de    = de_invert_n ? de_in : !de_in;
    end

    always_ff @(negedge clock) begin
        pix_fall_reg <= pix_now;
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !run_ok) begin
            pix_reg <= '0;
        end else begin
            pix_reg <= latch_edge_sel ? pix_now : pix_fall_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            VSLTX_ST_OFF: begin
                if (bit_error_test_en) begin
                    state_next = VSLTX_ST_BET;
                end else if (!hot_plug_n) begin
                    state_next = VSLTX_ST_TRAIN;
                end
            end
            VSLTX_ST_TRAIN: begin
                if (hot_plug_n) begin
                    state_next = VSLTX_ST_OFF;
                end else if (!rx_lock_n) begin
                    state_next = VSLTX_ST_RUN;
                end
            end
            VSLTX_ST_RUN: begin
                if (hot_plug_n) begin
                    state_next = VSLTX_ST_OFF;
                end else if (rx_lock_n) begin
                    state_next = VSLTX_ST_TRAIN;
                end
            end
            VSLTX_ST_BET: begin
                if (!bit_error_test_en) begin
                    state_next = VSLTX_ST_OFF;
                end
            end
            default: state_next = VSLTX_ST_OFF;
        endcase
        if (bit_error_test_en) begin
            state_next = VSLTX_ST_BET;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !run_ok) begin
            state_reg <= VSLTX_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // test pattern: prbs byte, simplified 8b/10b with running disparity, scramble
    always_ff @(posedge clock) begin
        if (sys_rst || !run_ok) begin
            prbs_reg <= PRBS_SEED;
            scr_reg  <= SCR_SEED;
            rd_reg   <= 1'b0;
        end else if (state_reg == VSLTX_ST_BET) begin
            prbs_reg <= {prbs_reg[14:0], prbs_reg[15] ^ prbs_reg[13]
                         ^ prbs_reg[12] ^ prbs_reg[10]};
            scr_reg  <= {scr_reg[14:0], scr_reg[15] ^ scr_reg[4]};
            rd_reg   <= !rd_reg;
        end
    end

    always_comb begin
        bet_sym = {prbs_reg[7:5] ^ {3{rd_reg}}, 1'b0, prbs_reg[4:0], 1'b1};
        bet_sym = bet_sym ^ scr_reg[9:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // word framing
    always_comb begin
        word_next = '0;
        case (state_reg)
            VSLTX_ST_TRAIN: word_next = TRAIN_WORD;
            VSLTX_ST_BET:   word_next = {4{bet_sym}};
            VSLTX_ST_RUN: begin
                if (pix_reg.de) begin
                    word_next = {2'h0, pix_reg.aux, pix_reg.red, pix_reg.green,
                                 pix_reg.blue, 1'b1, 5'h00};
                end else begin
                    word_next = {K28_5_RD_N, 24'h00_0000,
                                 1'b0, pix_reg.hsync, pix_reg.vsync,
                                 pix_reg.de, 2'h0};
                end
            end
            default: word_next = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // serializer timed only by the pixel clock
    always_ff @(posedge clock) begin
        if (sys_rst || !run_ok) begin
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
            ser_word_out <= '0;
            ser_word_load <= 1'b0;
        end else begin
            ser_word_load <= word_end;
            if (word_end) begin
                bit_cnt_reg  <= '0;
                shift_reg    <= word_next;
                ser_word_out <= word_next;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
                shift_reg   <= {shift_reg[SER_MAX-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !run_ok) begin
            serial_lane_out <= 1'b1;
        end else begin
            serial_lane_out <= shift_reg[SER_MAX-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog configuration
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link_cfg_out    <= '0;
            link_active     <= 1'b0;
            training_active <= 1'b0;
        end else begin
            link_cfg_out.power_ok     <= run_ok;
            link_cfg_out.emphasis     <= emphasis_sel && run_ok;
            link_cfg_out.drive_normal <= drive_level_sel;
            link_cfg_out.width24      <= width_sel;
            link_cfg_out.low_freq     <= low_freq_sel;
            link_active     <= (state_next != VSLTX_ST_OFF) && run_ok;
            training_active <= (state_next == VSLTX_ST_TRAIN) && run_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_pd_idle;
        @(posedge clock) disable iff (sys_rst)
        !power_down_n |=> serial_lane_out && !link_active;
    endproperty
    a_pd_idle: assert property (p_pd_idle) else $error("power-down not idle");

    property p_lock_run;
        @(posedge clock) disable iff (sys_rst)
        (state_reg == VSLTX_ST_TRAIN) && run_ok && !bit_error_test_en && !hot_plug_n
            && !rx_lock_n |=> state_reg == VSLTX_ST_RUN;
    endproperty
    a_lock_run: assert property (p_lock_run) else $error("lock ignored");

    property p_hp_train;
        @(posedge clock) disable iff (sys_rst)
        (state_reg == VSLTX_ST_OFF) && run_ok && !bit_error_test_en && !hot_plug_n
            |=> training_active ##0 state_reg == VSLTX_ST_TRAIN;
    endproperty
    a_hp_train: assert property (p_hp_train) else $error("no training");

    property p_relock;
        @(posedge clock) disable iff (sys_rst)
        (state_reg == VSLTX_ST_RUN) && run_ok && !bit_error_test_en && !hot_plug_n
            && rx_lock_n |=> state_reg == VSLTX_ST_TRAIN;
    endproperty
    a_relock: assert property (p_relock) else $error("no fallback");

    property p_bet;
        @(posedge clock) disable iff (sys_rst)
        run_ok && bit_error_test_en |=> state_reg == VSLTX_ST_BET;
    endproperty
    a_bet: assert property (p_bet) else $error("test mode missed");

    property p_aux24;
        @(posedge clock) disable iff (sys_rst)
        width_sel && $past(width_sel) |=> pix_reg.aux == 2'h0;
    endproperty
    a_aux24: assert property (p_aux24) else $error("aux leaked in 24-bit");

    property p_de_inv;
        @(posedge clock) disable iff (sys_rst)
        run_ok && latch_edge_sel
            |=> pix_reg.de == ($past(de_invert_n) ? $past(de_in) : !$past(de_in));
    endproperty
    a_de_inv: assert property (p_de_inv) else $error("enable polarity wrong");

    property p_frame;
        @(posedge clock) disable iff (sys_rst)
        ser_word_load |-> ##1 !ser_word_load [*8];
    endproperty
    a_frame: assert property (p_frame) else $error("word load spacing");

    property p_cfg;
        @(posedge clock) disable iff (sys_rst)
        run_ok |=> link_cfg_out.emphasis == $past(emphasis_sel)
            && link_cfg_out.drive_normal == $past(drive_level_sel)
            && link_cfg_out.width24 == $past(width_sel)
            && link_cfg_out.low_freq == $past(low_freq_sel);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config not forwarded");
endmodule

// ### shared/vsltx_pkg.sv
// Purpose: shared constants and types for the serial video link transmitter
// Assumes: one pixel clock domain
// Notes:   widths, patterns and state encodings
package vsltx_pkg;
    localparam int          CHAN_W      = 10;
    localparam int          DATA_W      = 32;
    localparam int          SYNC_W      = 3;
    localparam int          SYM_W       = 10;
    localparam int          WORD_W      = DATA_W + SYNC_W;
    localparam int          SER_MAX     = 40;
    localparam int          SER_24      = 30;
    localparam int          SER_32      = 40;
    localparam int          CNT_W       = 6;
    localparam int          MIN_KHZ_32  = 7500;
    localparam int          MAX_KHZ_32  = 75000;
    localparam int          MIN_MBPS    = 600;
    localparam int          MAX_MBPS    = 3000;
    localparam logic [9:0]  K28_5_RD_N  = 10'h0_0FA;
    localparam logic [39:0] TRAIN_WORD  = 40'h55_5555_5555;
    localparam logic [15:0] PRBS_SEED   = 16'hACE1;
    localparam logic [15:0] SCR_SEED    = 16'hFFFF;

    typedef enum logic [1:0] {
        VSLTX_ST_OFF   = 2'b00,
        VSLTX_ST_TRAIN = 2'b01,
        VSLTX_ST_RUN   = 2'b11,
        VSLTX_ST_BET   = 2'b10
    } vsltx_state_e;

    typedef struct packed {
        logic [CHAN_W-1:0] red;
        logic [CHAN_W-1:0] green;
        logic [CHAN_W-1:0] blue;
        logic [1:0]        aux;
        logic              hsync;
        logic              vsync;
        logic              de;
    } vsltx_pixel_s;

    typedef struct packed {
        logic power_ok;
        logic emphasis;
        logic drive_normal;
        logic width24;
        logic low_freq;
    } vsltx_link_cfg_s;
endpackage
